/* File: verilog/led_status_consts.svh */
`ifndef LED_STATUS_CONSTS_SVH
`define LED_STATUS_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CONTROL        4'h0
`define OFS_STATUS         4'h4
`define OFS_IRQ_STATUS     4'h8
`define OFS_IRQ_MASK       4'hc

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define CTL_INIT_DONE      0
`define CTL_TIME_VALID     1
`define CTL_GPS_OK         2
`define CTL_ANT_FAULT      3
`define CTL_OUT_FAULT      4
`define CTL_MODE_LSB       8
`define CTL_MODE_MSB       10

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define ST_ALARM_LSB       0
`define ST_READY_LSB       2
`define ST_POWER_LSB       4
`define ST_COAST           6
`define ST_FAULT           7
`define ST_HOLD_LSB        8
`define ST_HOLD_MSB        15

// ----------------------------------------------------------------------
// interrupt bit positions
// ----------------------------------------------------------------------
`define IRQ_COAST          0
`define IRQ_FAULT          1
`define IRQ_TIME_VALID     2
`define IRQ_NUM            3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CONTROL_RESET      32'h0000_0000
`define IRQ_MASK_RESET     3'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_HZ             250000000
`define SLOW_BLINK_MS      500
`define FAST_BLINK_MS      100
`define SLOW_HALF_CYC      (`CLK_HZ / 1000 * `SLOW_BLINK_MS)
`define FAST_HALF_CYC      (`CLK_HZ / 1000 * `FAST_BLINK_MS)
`define TICK_CYC           `CLK_HZ
`define COAST_MINUTES      60
`define COAST_SECONDS      (`COAST_MINUTES * 60)
`define STARTUP_MS         2000
`define STARTUP_CYC        (`CLK_HZ / 1000 * `STARTUP_MS)

`endif

/* File: verilog/led_status_pkg.sv */
package led_status_pkg;

   // indicator display state
   typedef enum logic [1:0] {
      led_off   = 2'h0,
      led_on    = 2'h1,
      led_flash = 2'h3,
      led_rapid = 2'h2
   } led_look_type;

   // oscillator tuning mode
   typedef enum logic [2:0] {
      mode_none        = 3'h0,
      mode_warmup      = 3'h1,
      mode_coarse      = 3'h2,
      mode_coarse_hold = 3'h3,
      mode_fine        = 3'h4,
      mode_fine_hold   = 3'h5
   } tune_mode_type;

   typedef struct packed {
      logic [1:0] power;
      logic [1:0] ready;
      logic [1:0] alarm;
   } led_set_type;

   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } wb_req_type;

   typedef struct packed {
      logic [31:0] dat;
      logic        ack;
      logic        err;
   } wb_rsp_type;

endpackage

/* File: verilog/led_status_indicator.sv */
// Function
// [RULE_01] alarm flashes rapidly at startup, then steady until time valid
// [RULE_02] alarm off once time valid while conditions stay usable
// [RULE_03] alarm flashes when gps lost in coarse or fine tuning
// [RULE_04] coast alarm after over 60 minutes in fine hold; alarm steady
// [RULE_05] power flashes rapidly at startup, then steady while operating
// [RULE_06] hardware fault turns power indicator from steady to flashing
// [RULE_07] after startup the fault flash beats the steady power state
// [RULE_08] ready flashes rapidly at startup, then off until gps acquired
// [RULE_09] ready flashes once coarse tuning is entered
// [RULE_10] ready off while coarse tuning interrupted, flashes on resume
// [RULE_11] ready steady on entry to fine tuning
// [RULE_12] fine tuning hold flashes both ready and alarm
// [RULE_13] ready off in coast alarm
// [RULE_14] warm-up without valid time: alarm steady, ready off
// [RULE_15] warm-up with valid time: alarm and ready off
// [RULE_16] coarse hold: alarm flashes, ready off
// [RULE_17] tuning mode codes 1 warm-up to 5 fine hold
// [RULE_18] two blink rates from the clock, near equal on and off
// [RULE_19] hold timer restarts per fine hold entry, seconds tick, clears
//
// The Wishbone slave port and the placing of the registers were decided locally.
`include "led_status_consts.svh"

module led_status_indicator #(
   parameter int unsigned SLOW_HALF    = `SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF    = `FAST_HALF_CYC,
   parameter int unsigned TICK         = `TICK_CYC,
   parameter int unsigned STARTUP      = `STARTUP_CYC,
   parameter int unsigned COAST_SEC    = `COAST_SECONDS
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire led_status_pkg::wb_req_type wb_req,
   output      led_status_pkg::wb_rsp_type wb_rsp,
   output      logic                      alarm_led,
   output      logic                      power_led,
   output      logic                      ready_led,
   output      logic                      irq
);
   import led_status_pkg::*;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   // control (0x0, read/write, byte enables honoured)
   //    bit 0      initialisation finished
   //    bit 1      time valid
   //    bit 2      gps input present
   //    bit 3      antenna or antenna cable fault
   //    bit 4      frequency output fault
   //    bits 10:8  tuning mode, 0, 6 and 7 shown as warm-up
   //    other bits stored and read back as written
   // status (0x4, read only, writes acknowledged and dropped)
   //    bits 5:0   indicator looks: power, ready, alarm
   //    bit 6      coast alarm
   //    bit 7      hardware fault
   //    bits 15:8  seconds in fine hold, saturating at 255
   // interrupt status (0x8, write one to clear) and mask (0xc)
   //    bit 0      coast alarm raised
   //    bit 1      hardware fault raised
   //    bit 2      time became valid
   logic [31:0]           control;
   logic [`IRQ_NUM-1:0]   irq_status;
   logic [`IRQ_NUM-1:0]   irq_mask;
   logic [`IRQ_NUM-1:0]   irq_event;
   logic [31:0]           rd_data;
   logic                  hit;
   logic                  wr_ack;
   logic                  ack_q;

   tune_mode_type         mode;
   logic                  init_done;
   logic                  time_valid;
   logic                  gps_ok;
   logic                  hw_fault;
   logic                  startup_over;
   logic                  coast;
   logic                  coarse_stalled;
   logic [31:0]           startup_cnt;
   logic [31:0]           slow_cnt;
   logic [31:0]           fast_cnt;
   logic [31:0]           tick_cnt;
   logic                  sec_tick;
   logic                  slow_phase;
   logic                  fast_phase;
   logic [31:0]           hold_sec;
   tune_mode_type         prev_mode;
   logic                  coast_q;
   logic                  fault_q;
   logic                  valid_q;
   led_set_type           look;

   assign mode       = tune_mode_type'(control[`CTL_MODE_MSB:`CTL_MODE_LSB]);
   assign init_done  = control[`CTL_INIT_DONE];
   assign time_valid = control[`CTL_TIME_VALID];
   assign gps_ok     = control[`CTL_GPS_OK];
   assign hw_fault   = control[`CTL_ANT_FAULT] | control[`CTL_OUT_FAULT];

   // ----------------------------------------------------------------------
   // wishbone slave: one wait state, err on unmapped address
   // ----------------------------------------------------------------------
   assign hit = (wb_req.adr[3:0] == `OFS_CONTROL) ||
                (wb_req.adr[3:0] == `OFS_STATUS) ||
                (wb_req.adr[3:0] == `OFS_IRQ_STATUS) ||
                (wb_req.adr[3:0] == `OFS_IRQ_MASK);
   // ack_q keeps a still-held request from being taken twice
   assign wr_ack = wb_req.cyc & wb_req.stb & ~ack_q & wb_req.we & hit;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_q      <= 1'b0;
         wb_rsp     <= '0;
      end else begin
         ack_q      <= wb_req.cyc & wb_req.stb & ~ack_q;
         wb_rsp.ack <= wb_req.cyc & wb_req.stb & ~ack_q & hit;
         wb_rsp.err <= wb_req.cyc & wb_req.stb & ~ack_q & ~hit;
         wb_rsp.dat <= rd_data;
      end
   end

   // unmapped offsets read as zero and are answered with err
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (wb_req.adr[3:0])
         `OFS_CONTROL:    rd_data = control;
         `OFS_STATUS: begin
            rd_data[5:0]                      = look;
            rd_data[`ST_COAST]                = coast;
            rd_data[`ST_FAULT]                = hw_fault;
            // a hold longer than the field reads as 255
            rd_data[`ST_HOLD_MSB:`ST_HOLD_LSB] =
               (hold_sec[31:8] != 24'h0) ? 8'hff : hold_sec[7:0];
         end
         `OFS_IRQ_STATUS: rd_data[`IRQ_NUM-1:0] = irq_status;
         `OFS_IRQ_MASK:   rd_data[`IRQ_NUM-1:0] = irq_mask;
         default:         rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         control <= `CONTROL_RESET;
      end else if (wr_ack && wb_req.adr[3:0] == `OFS_CONTROL) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_req.sel[b]) begin
               control[b*8 +: 8] <= wb_req.dat[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_mask <= `IRQ_MASK_RESET;
      end else if (wr_ack && wb_req.adr[3:0] == `OFS_IRQ_MASK &&
                   wb_req.sel[0]) begin
         irq_mask <= wb_req.dat[`IRQ_NUM-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // interrupts: rising edges of coast, fault and time valid
   // ----------------------------------------------------------------------
   // edges, not levels: a standing fault raises its bit once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         coast_q <= 1'b0;
         fault_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         coast_q <= coast;
         fault_q <= hw_fault;
         valid_q <= time_valid;
      end
   end

   always_comb begin
      irq_event                 = '0;
      irq_event[`IRQ_COAST]      = coast & ~coast_q;
      irq_event[`IRQ_FAULT]      = hw_fault & ~fault_q;
      irq_event[`IRQ_TIME_VALID] = time_valid & ~valid_q;
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_status <= '0;
      end else if (wr_ack && wb_req.adr[3:0] == `OFS_IRQ_STATUS &&
                   wb_req.sel[0]) begin
         irq_status <= (irq_status & ~wb_req.dat[`IRQ_NUM-1:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------------------------------------
   // blink rates and one-second tick
   // ----------------------------------------------------------------------
   // whole half periods are counted, so on and off times match
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slow_cnt   <= 32'h0;
         slow_phase <= 1'b0;
      end else if (slow_cnt >= SLOW_HALF - 1) begin
         slow_cnt   <= 32'h0;
         slow_phase <= ~slow_phase;                        // [RULE_18]
      end else begin
         slow_cnt   <= slow_cnt + 32'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fast_cnt   <= 32'h0;
         fast_phase <= 1'b0;
      end else if (fast_cnt >= FAST_HALF - 1) begin
         fast_cnt   <= 32'h0;
         fast_phase <= ~fast_phase;                        // [RULE_18]
      end else begin
         fast_cnt   <= fast_cnt + 32'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_cnt <= 32'h0;
         sec_tick <= 1'b0;
      end else begin
         // one-cycle pulse at the end of every TICK cycles
         sec_tick <= (tick_cnt >= TICK - 1);
         tick_cnt <= (tick_cnt >= TICK - 1) ? 32'h0 : tick_cnt + 32'h1;
      end
   end

   // ----------------------------------------------------------------------
   // startup: rapid flash for a short time, then until init done
   // ----------------------------------------------------------------------
   // an early init_done cannot cut the rapid phase short
   always_ff @(posedge core_clk) begin
      if (rst) begin
         startup_cnt  <= 32'h0;
         startup_over <= 1'b0;
      end else if (startup_cnt < STARTUP - 1) begin
         startup_cnt  <= startup_cnt + 32'h1;
      end else if (init_done) begin
         startup_over <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // holdover timer
   // ----------------------------------------------------------------------
   // counting stops one past the limit, so coast holds without wrapping
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_mode <= mode_none;
         hold_sec  <= 32'h0;
      end else begin
         prev_mode <= mode;
         if (mode != mode_fine_hold || prev_mode != mode_fine_hold) begin
            hold_sec <= 32'h0;                             // [RULE_19]
         end else if (sec_tick && hold_sec <= COAST_SEC) begin
            hold_sec <= hold_sec + 32'h1;                  // [RULE_19]
         end
      end
   end

   // fine hold is only reached through fine tuning
   assign coast = (mode == mode_fine_hold) &&
                  (hold_sec > COAST_SEC);                  // [RULE_04]
   assign coarse_stalled = (mode == mode_coarse) && !gps_ok;

   // ----------------------------------------------------------------------
   // indicator states
   // ----------------------------------------------------------------------
   always_comb begin
      look.alarm = led_off;
      look.ready = led_off;
      look.power = led_on;                                 // [RULE_05]
      if (!startup_over) begin
         look.alarm = led_rapid;                           // [RULE_01]
         look.ready = led_rapid;                           // [RULE_08]
         look.power = led_rapid;                           // [RULE_05]
      end else begin
         unique case (mode)                                // [RULE_17]
            mode_coarse: begin
               if (coarse_stalled) begin
                  look.alarm = led_flash;                  // [RULE_03]
                  look.ready = led_off;                    // [RULE_10]
               end else begin
                  look.alarm = led_off;                    // [RULE_02]
                  look.ready = led_flash;                  // [RULE_09]
               end
            end
            mode_coarse_hold: begin
               look.alarm = led_flash;                     // [RULE_16]
               look.ready = led_off;                       // [RULE_16]
            end
            mode_fine: begin
               if (gps_ok) begin
                  look.alarm = led_off;                    // [RULE_02]
               end else begin
                  look.alarm = led_flash;                  // [RULE_03]
               end
               look.ready = led_on;                        // [RULE_11]
            end
            mode_fine_hold: begin
               if (coast) begin
                  look.alarm = led_on;                     // [RULE_04]
                  look.ready = led_off;                    // [RULE_13]
               end else begin
                  look.alarm = led_flash;                  // [RULE_12]
                  look.ready = led_flash;                  // [RULE_12]
               end
            end
            default: begin
               // warm-up, mode not yet reported, or unused codes 6 and 7
               if (time_valid) begin
                  look.alarm = led_off;                    // [RULE_15]
               end else begin
                  look.alarm = led_on;                     // [RULE_14]
               end
               look.ready = led_off;                     // [RULE_08] [RULE_14]
            end
         endcase
         if (hw_fault) begin
            look.power = led_flash;                      // [RULE_06] [RULE_07]
         end
      end
   end

   // lamp level for a look, given the slow and fast blink phases
   function automatic logic drive(input logic [1:0] l, input logic s,
                                  input logic f);
      logic r;
      unique case (l)
         led_off:   r = 1'b0;
         led_on:    r = 1'b1;
         led_flash: r = s;
         default:   r = f;
      endcase
      return r;
   endfunction

   // one register per lamp, so every lamp output is glitch free
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alarm_led <= 1'b0;
      end else begin
         alarm_led <= drive(look.alarm, slow_phase, fast_phase);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         power_led <= 1'b0;
      end else begin
         power_led <= drive(look.power, slow_phase, fast_phase);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ready_led <= 1'b0;
      end else begin
         ready_led <= drive(look.ready, slow_phase, fast_phase);
      end
   end

endmodule

/* File: testbench/led_viewer.sv */
// ---------------------------------------------------------------
// operator's eye: length of the last complete lit or dark run
// ---------------------------------------------------------------
module led_viewer (
   input  wire logic       core_clk,
   input  wire logic       led,
   output      logic [7:0] run
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] count = 8'h00;
   logic       last  = 1'b0;

   // a run ends when the level changes; its length is latched
   always_ff @(posedge core_clk) begin
      last <= led;
      if (led != last) begin
         run   <= count;
         count <= 8'h01;
      end else if (count != 8'hff) begin
         count <= count + 8'h01;
      end
   end
endmodule

/* File: testbench/led_status_properties.sv */
module led_status_checker (
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire led_status_pkg::wb_req_type wb_req,
   input wire led_status_pkg::wb_rsp_type wb_rsp,
   input wire logic                       alarm_led,
   input wire logic                       power_led,
   input wire logic                       ready_led,
   input wire logic                       irq
);
   import led_status_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic req;
   logic mapped;
   assign req    = wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_rsp.err;
   assign mapped = wb_req.adr[1:0] == 2'h0;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // bus and indicator properties
   // ---------------------------------------------------------------
   answer_next_a: assert property (req |=> wb_rsp.ack || wb_rsp.err)
      else $error("request not answered in the next cycle");
   mapped_ack_a: assert property (req && mapped |=> wb_rsp.ack && !wb_rsp.err)
      else $error("mapped access not acknowledged");
   unmapped_err_a: assert property (req && !mapped |=>
      wb_rsp.err && !wb_rsp.ack)
      else $error("unmapped access not refused");
   answer_pulse_a: assert property (wb_rsp.ack || wb_rsp.err |=>
      !wb_rsp.ack && !wb_rsp.err)
      else $error("answer held longer than one cycle");
   idle_quiet_a: assert property (!(wb_req.cyc && wb_req.stb) |=>
      !wb_rsp.ack && !wb_rsp.err)
      else $error("answer without a request");
   mask_off_a: assert property (wb_rsp.ack && wb_req.we &&
      wb_req.adr[3:0] == 4'hc && wb_req.sel[0] && wb_req.dat[2:0] == 3'h0
      |-> !irq)
      else $error("irq high after all sources masked");
   reset_dark_a: assert property (disable iff (1'b0) rst |=> !alarm_led &&
      !power_led && !ready_led && !irq && !wb_rsp.ack)
      else $error("outputs active during reset");
   startup_same_a: assert property ($fell(rst) |=>
      (alarm_led == power_led && power_led == ready_led)[*4])
      else $error("indicators not flashing together at startup");

   cover property (req && !mapped);
   cover property (irq);
   cover property ($rose(ready_led));
endmodule

bind led_status_indicator led_status_checker i_checker (
   .core_clk  (core_clk),
   .rst       (rst),
   .wb_req    (wb_req),
   .wb_rsp    (wb_rsp),
   .alarm_led (alarm_led),
   .power_led (power_led),
   .ready_led (ready_led),
   .irq       (irq)
);

/* File: testbench/led_status_indicator_bench.sv */
module led_status_indicator_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import led_status_pkg::*;

   localparam int SLOW = 4;
   localparam int FAST = 2;

   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   wb_req_type  wb_req   = '0;
   wb_rsp_type  wb_rsp;
   logic        alarm_led;
   logic        power_led;
   logic        ready_led;
   logic        irq;
   logic [7:0]  alarm_run;
   logic [7:0]  ready_run;
   logic [7:0]  power_run;
   logic [31:0] q;
   logic        e;
   int          n_errors = 0;
   int          n_tests  = 0;
   int          cycles   = 0;

   led_status_indicator #(.SLOW_HALF(SLOW), .FAST_HALF(FAST), .TICK(10),
      .STARTUP(8), .COAST_SEC(3)) i_dut (
      .core_clk  (core_clk),
      .rst       (rst),
      .wb_req    (wb_req),
      .wb_rsp    (wb_rsp),
      .alarm_led (alarm_led),
      .power_led (power_led),
      .ready_led (ready_led),
      .irq       (irq)
   );
   led_viewer i_alarm_eye (
      .core_clk (core_clk),
      .led      (alarm_led),
      .run      (alarm_run)
   );
   led_viewer i_ready_eye (
      .core_clk (core_clk),
      .led      (ready_led),
      .run      (ready_run)
   );
   led_viewer i_power_eye (
      .core_clk (core_clk),
      .led      (power_led),
      .run      (power_run)
   );

   initial begin
      forever #2 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors = n_errors + 1;
         end_of_test();
      end
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                            input string msg);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got,
                  exp);
      end
   endtask

   // one classic cycle; holds the request until ack or err is sampled
   task automatic bus(input logic [3:0] a, input logic we,
                      input logic [31:0] d);
      @(posedge core_clk);
      wb_req <= '{adr: {28'h0, a}, dat: d, sel: 4'hf, we: we, cyc: 1'b1,
                  stb: 1'b1};
      do begin
         @(posedge core_clk);
      end while (!(wb_rsp.ack || wb_rsp.err));
      q = wb_rsp.dat;
      e = wb_rsp.err;
      check_val({31'h0, e}, {31'h0, a[1:0] != 2'h0}, "answer kind");
      wb_req <= '0;
   endtask

   task automatic step(input logic [31:0] c, input logic [5:0] look);
      bus(4'h0, 1'b1, c);
      repeat (3) @(posedge core_clk);
      bus(4'h4, 1'b0, 32'h0);
      check_val({26'h0, q[5:0]}, {26'h0, look}, "indicator looks");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      bus(4'hc, 1'b0, 32'h0);
      check_val(q, 32'h0, "mask reset value");
      repeat (20) @(posedge core_clk);
      bus(4'h4, 1'b0, 32'h0);
      check_val({26'h0, q[5:0]}, {26'h0, led_rapid, led_rapid, led_rapid},
                "startup looks");
      check_val({24'h0, alarm_run}, FAST, "rapid rate");
      step(32'h101, {led_on, led_off, led_on});
      step(32'h103, {led_on, led_off, led_off});
      bus(4'h8, 1'b0, 32'h0);
      check_val(q & 32'h7, 32'h4, "time valid event");
      check_val({31'h0, irq}, 32'h0, "masked irq");
      bus(4'hc, 1'b1, 32'h4);
      check_val({31'h0, irq}, 32'h1, "unmasked irq");
      bus(4'h8, 1'b1, 32'h4);
      check_val({31'h0, irq}, 32'h0, "irq after clear");
      bus(4'h2, 1'b0, 32'h0);
      check_val({31'h0, e}, 32'h1, "unmapped refused");
      step(32'h207, {led_on, led_flash, led_off});
      repeat (20) @(posedge core_clk);
      check_val({24'h0, ready_run}, SLOW, "slow rate");
      step(32'h203, {led_on, led_off, led_flash});
      step(32'h207, {led_on, led_flash, led_off});
      step(32'h303, {led_on, led_off, led_flash});
      step(32'h407, {led_on, led_on, led_off});
      check_val({29'h0, power_led, ready_led, alarm_led}, 32'h6, "lamps");
      step(32'h403, {led_on, led_on, led_flash});
      step(32'h503, {led_on, led_flash, led_flash});
      check_val({31'h0, q[6]}, 32'h0, "no coast yet");
      repeat (60) @(posedge core_clk);
      bus(4'h4, 1'b0, 32'h0);
      check_val({26'h0, q[5:0]}, {26'h0, led_on, led_off, led_on},
                "coast looks");
      check_val({31'h0, q[6]}, 32'h1, "coast flag");
      check_val({29'h0, power_led, ready_led, alarm_led}, 32'h5, "coast");
      bus(4'h8, 1'b0, 32'h0);
      check_val(q & 32'h1, 32'h1, "coast event");
      step(32'h407, {led_on, led_on, led_off});
      check_val({24'h0, q[15:8]}, 32'h0, "hold time cleared");
      step(32'h40f, {led_flash, led_on, led_off});
      check_val({31'h0, q[7]}, 32'h1, "fault flag");
      repeat (20) @(posedge core_clk);
      check_val({24'h0, power_run}, SLOW, "fault flash rate");
      step(32'h417, {led_flash, led_on, led_off});
      bus(4'h4, 1'b1, 32'hffff_ffff);
      bus(4'h0, 1'b0, 32'h0);
      check_val(q & 32'h71f, 32'h417, "control read back");
      bus(4'h4, 1'b0, 32'h0);
      check_val({26'h0, q[5:0]}, {26'h0, led_flash, led_on, led_off},
                "status read only");
      bus(4'h8, 1'b0, 32'h0);
      check_val(q & 32'h2, 32'h2, "fault event");
      bus(4'hc, 1'b1, 32'h0);
      check_val({31'h0, irq}, 32'h0, "all masked");
      end_of_test();
   end
endmodule
